// [logic/tcf_timer.sv]
// tcf_timer: counter, status flags, two capture channels and compare one.
// assumes an APB master on CLOCK; pins are synchronous to CLOCK.
//
// How it works
// - flag register read-only at 13h
// - capture-one flag: set on edge, status-then-low clear
// - compare-one flag: set on match, status-then-low clear
// - overflow flag: set on wrap, status-then-counter-low clear
// - capture-two flag: falling edge, status-then-low clear
// - compare-two flag: match input, status-then-low clear
// - shared capture enable, shared compare enable
// - capture one latches counter, high 14h low 15h
// - captured value is preceding count plus one
// - capture resolution one count, four clocks
// - every unblocked valid edge overwrites capture register
// - high byte read blocks capture until low read
// - low byte read alone never blocks capture
// - capture two on falling edges, 1Ch/1Dh
// - reset leaves capture registers untouched
// - compare one matched continuously, sets flag, pin
// - high write suspends matching until low write
// - each compare byte written independently
// - every match clocks level onto compare pin
// - compare bytes plain storage, never reset
// - edge select: one rising, zero falling
// - counter preset FFFCh, divide-by-four prescaler
//
// Our own choice: register access over APB.
`timescale 1ns/10ps

module tcf_timer #(
   parameter int DIV = tcf_pkg::PRESC_DIV
) (
   input  wire logic       CLOCK,
   input  wire logic       RST,
   input  wire logic       CE,
   input  wire logic       PSEL,
   input  wire logic       PENABLE,
   input  wire logic       PWRITE,
   input  wire logic [7:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]     PRDATA,
   output logic            PREADY,
   output logic            PSLVERR,
   input  wire logic       CAPTURE_ONE_PIN,
   input  wire logic       CAPTURE_TWO_PIN,
   input  wire logic       COMPARE_TWO_MATCH,
   output logic            COMPARE_ONE_PIN,
   output logic            TIMER_IRQ
);
   import tcf_pkg::*;

   localparam int PW = $clog2(DIV);
   localparam logic [PW-1:0] PRESC_LAST = PW'(DIV - 1);
   localparam logic [PW-1:0] PRESC_ZERO = '0;

   tcf_ctrl_t   ctrl;
   tcf_flags_t  flags;
   logic [PW-1:0] presc;
   logic [15:0] cnt;
   logic [15:0] cap1;
   logic [15:0] cap2;
   logic [15:0] cmp1;
   logic [7:0]  cnt_buf;
   logic        cnt_buf_valid;
   logic        cap1_lock;
   logic        cap2_lock;
   logic        cmp1_inhibit;
   logic        pin1_q;
   logic        pin2_q;
   logic        pins_armed;
   tcf_flags_t  armed;

   logic        done;
   logic        rd_done;
   logic        wr_done;
   logic        tick;
   logic        ovf;
   logic        cmp1_match;
   logic        cap1_edge;
   logic        cap2_edge;
   logic        cap1_take;
   logic        cap2_take;
   logic [7:0]  next_rdata;
   logic        next_err;

   // ---------------------------------------------------------------------
   // address decoding
   // ---------------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
      hit = (a == tcf_addr(idx));
   endfunction : hit

   assign done    = PSEL & PENABLE & PREADY;
   assign rd_done = done & ~PWRITE;
   assign wr_done = done & PWRITE;

   // ---------------------------------------------------------------------
   // counter and prescaler
   // ---------------------------------------------------------------------
   assign tick = (presc == PRESC_LAST);
   assign ovf  = tick & (cnt == CNT_TOP);

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         presc <= '0;
         cnt   <= CNT_PRESET;
      end else if (CE) begin
         presc <= tick ? PRESC_ZERO : presc + PW'(1);
         if (tick) begin
            cnt <= cnt + 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ctrl <= tcf_ctrl_t'({CTRL_RESET[CTRL_CAP_IE_BIT],
                              CTRL_RESET[CTRL_CMP_IE_BIT],
                              CTRL_RESET[CTRL_OVF_IE_BIT],
                              CTRL_RESET[CTRL_EDGE1_BIT],
                              CTRL_RESET[CTRL_LEVEL1_BIT]});
      end else if (CE && wr_done && hit(PADDR, IDX_CTRL)) begin
         ctrl.capture_irq_enable      <= PWDATA[CTRL_CAP_IE_BIT];
         ctrl.compare_irq_enable      <= PWDATA[CTRL_CMP_IE_BIT];
         ctrl.overflow_irq_enable     <= PWDATA[CTRL_OVF_IE_BIT];
         ctrl.capture_one_edge_select <= PWDATA[CTRL_EDGE1_BIT];
         ctrl.compare_one_level       <= PWDATA[CTRL_LEVEL1_BIT];
      end
   end

   // ---------------------------------------------------------------------
   // capture edge detection
   // ---------------------------------------------------------------------
   // armed bit keeps a pin already high at reset release from capturing
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         pin1_q     <= 1'b0;
         pin2_q     <= 1'b0;
         pins_armed <= 1'b0;
      end else if (CE) begin
         pin1_q     <= CAPTURE_ONE_PIN;
         pin2_q     <= CAPTURE_TWO_PIN;
         pins_armed <= 1'b1;
      end
   end

   assign cap1_edge = pins_armed & (ctrl.capture_one_edge_select ?
                      (CAPTURE_ONE_PIN & ~pin1_q) :
                      (~CAPTURE_ONE_PIN & pin1_q));
   assign cap2_edge = pins_armed & ~CAPTURE_TWO_PIN & pin2_q;

   // a low-byte read in the same cycle lifts the block at once
   assign cap1_take = cap1_edge & ~(cap1_lock &
                      ~(rd_done & hit(PADDR, IDX_CAP1_LO)));
   assign cap2_take = cap2_edge & ~(cap2_lock &
                      ~(rd_done & hit(PADDR, IDX_CAP2_LO)));

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cap1_lock <= 1'b0;
         cap2_lock <= 1'b0;
      end else if (CE && rd_done) begin
         if (hit(PADDR, IDX_CAP1_HI)) begin
            cap1_lock <= 1'b1;
         end else if (hit(PADDR, IDX_CAP1_LO)) begin
            cap1_lock <= 1'b0;
         end
         if (hit(PADDR, IDX_CAP2_HI)) begin
            cap2_lock <= 1'b1;
         end else if (hit(PADDR, IDX_CAP2_LO)) begin
            cap2_lock <= 1'b0;
         end
      end
   end

   // no reset: captured values survive a reset
   always_ff @(posedge CLOCK) begin
      if (CE && cap1_take) begin
         cap1 <= cnt + 16'h0001;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (CE && cap2_take) begin
         cap2 <= cnt + 16'h0001;
      end
   end

   // ---------------------------------------------------------------------
   // compare one
   // ---------------------------------------------------------------------
   // compared once per count, in the first clock of the new value
   assign cmp1_match = (presc == PRESC_ZERO) & (cnt == cmp1) &
                       ~cmp1_inhibit;

   // no reset: plain storage as far as software is concerned
   always_ff @(posedge CLOCK) begin
      if (CE && wr_done) begin
         if (hit(PADDR, IDX_CMP1_HI)) begin
            cmp1[15:8] <= PWDATA[7:0];
         end
         if (hit(PADDR, IDX_CMP1_LO)) begin
            cmp1[7:0] <= PWDATA[7:0];
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cmp1_inhibit <= 1'b0;
      end else if (CE && wr_done) begin
         if (hit(PADDR, IDX_CMP1_HI)) begin
            cmp1_inhibit <= 1'b1;
         end else if (hit(PADDR, IDX_CMP1_LO)) begin
            cmp1_inhibit <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         COMPARE_ONE_PIN <= LEVEL_RESET;
      end else if (CE && cmp1_match) begin
         COMPARE_ONE_PIN <= ctrl.compare_one_level;
      end
   end

   // ---------------------------------------------------------------------
   // counter read buffer
   // ---------------------------------------------------------------------
   // high-byte read freezes the low byte so the pair is coherent
   // low byte taken at the edge that samples the high byte: a tick between
   // setup and completion would otherwise tear the pair
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cnt_buf <= 8'h00;
      end else if (CE && PSEL && !PREADY && !PWRITE && !cnt_buf_valid &&
                   (hit(PADDR, IDX_CNT_HI) || hit(PADDR, IDX_ALT_HI))) begin
         cnt_buf <= cnt[7:0];
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cnt_buf_valid <= 1'b0;
      end else if (CE && rd_done) begin
         if (hit(PADDR, IDX_CNT_HI) || hit(PADDR, IDX_ALT_HI)) begin
            cnt_buf_valid <= 1'b1;
         end else if (hit(PADDR, IDX_CNT_LO) || hit(PADDR, IDX_ALT_LO)) begin
            cnt_buf_valid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------------
   // status flags
   // ---------------------------------------------------------------------
   // a flag other than overflow is armed for clearing only if it read as set in the status
   // byte, overflow if set at any status access; a set arriving in the clearing cycle wins
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         armed <= '0;
      end else if (CE) begin
         if (done && hit(PADDR, IDX_FLAGS)) begin
            armed.capture_one_flag <= ~PWRITE & PRDATA[FLG_CAP1_BIT];
            armed.compare_one_flag <= ~PWRITE & PRDATA[FLG_CMP1_BIT];
            armed.overflow_flag    <= flags.overflow_flag;
            armed.capture_two_flag <= ~PWRITE & PRDATA[FLG_CAP2_BIT];
            armed.compare_two_flag <= ~PWRITE & PRDATA[FLG_CMP2_BIT];
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         flags <= '0;
      end else if (CE) begin
         if (rd_done && hit(PADDR, IDX_CAP1_LO) && armed.capture_one_flag)
         begin
            flags.capture_one_flag <= 1'b0;
         end
         if (done && hit(PADDR, IDX_CMP1_LO) && armed.compare_one_flag)
         begin
            flags.compare_one_flag <= 1'b0;
         end
         if (rd_done && hit(PADDR, IDX_CNT_LO) && armed.overflow_flag)
         begin
            flags.overflow_flag <= 1'b0;
         end
         if (rd_done && hit(PADDR, IDX_CAP2_LO) && armed.capture_two_flag)
         begin
            flags.capture_two_flag <= 1'b0;
         end
         if (done && hit(PADDR, IDX_CMP2_LO) && armed.compare_two_flag)
         begin
            flags.compare_two_flag <= 1'b0;
         end
         if (cap1_edge) begin
            flags.capture_one_flag <= 1'b1;
         end
         if (cmp1_match) begin
            flags.compare_one_flag <= 1'b1;
         end
         if (ovf) begin
            flags.overflow_flag <= 1'b1;
         end
         if (cap2_edge) begin
            flags.capture_two_flag <= 1'b1;
         end
         if (COMPARE_TWO_MATCH) begin
            flags.compare_two_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         TIMER_IRQ <= 1'b0;
      end else if (CE) begin
         TIMER_IRQ <= (ctrl.capture_irq_enable &
                       (flags.capture_one_flag | flags.capture_two_flag)) |
                      (ctrl.compare_irq_enable &
                       (flags.compare_one_flag | flags.compare_two_flag)) |
                      (ctrl.overflow_irq_enable & flags.overflow_flag);
      end
   end

   // ---------------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------------
   // read data sampled at the first enabled edge of a transfer, so a setup
   // missed while CE is low still gets its one access cycle
   always_comb begin
      next_rdata = 8'h00;
      next_err   = 1'b0;
      if (hit(PADDR, IDX_CTRL)) begin
         next_rdata[CTRL_CAP_IE_BIT] = ctrl.capture_irq_enable;
         next_rdata[CTRL_CMP_IE_BIT] = ctrl.compare_irq_enable;
         next_rdata[CTRL_OVF_IE_BIT] = ctrl.overflow_irq_enable;
         next_rdata[CTRL_EDGE1_BIT]  = ctrl.capture_one_edge_select;
         next_rdata[CTRL_LEVEL1_BIT] = ctrl.compare_one_level;
      end else if (hit(PADDR, IDX_FLAGS)) begin
         next_rdata[FLG_CAP1_BIT] = flags.capture_one_flag;
         next_rdata[FLG_CMP1_BIT] = flags.compare_one_flag;
         next_rdata[FLG_OVF_BIT]  = flags.overflow_flag;
         next_rdata[FLG_CAP2_BIT] = flags.capture_two_flag;
         next_rdata[FLG_CMP2_BIT] = flags.compare_two_flag;
      end else if (hit(PADDR, IDX_CAP1_HI)) begin
         next_rdata = cap1[15:8];
      end else if (hit(PADDR, IDX_CAP1_LO)) begin
         next_rdata = cap1[7:0];
      end else if (hit(PADDR, IDX_CMP1_HI)) begin
         next_rdata = cmp1[15:8];
      end else if (hit(PADDR, IDX_CMP1_LO)) begin
         next_rdata = cmp1[7:0];
      end else if (hit(PADDR, IDX_CNT_HI) || hit(PADDR, IDX_ALT_HI)) begin
         next_rdata = cnt[15:8];
      end else if (hit(PADDR, IDX_CNT_LO) || hit(PADDR, IDX_ALT_LO)) begin
         next_rdata = cnt_buf_valid ? cnt_buf : cnt[7:0];
      end else if (hit(PADDR, IDX_CAP2_HI)) begin
         next_rdata = cap2[15:8];
      end else if (hit(PADDR, IDX_CAP2_LO)) begin
         next_rdata = cap2[7:0];
      end else if (hit(PADDR, IDX_CMP2_HI) || hit(PADDR, IDX_CMP2_LO)) begin
         next_rdata = 8'h00;
      end else begin
         next_err = 1'b1;
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         PREADY <= PSEL & ~PREADY;
         if (PSEL && !PREADY) begin
            PRDATA  <= PWRITE ? 32'h00000000 : {24'h000000, next_rdata};
            PSLVERR <= next_err;
         end else begin
            PSLVERR <= 1'b0;
         end
      end
   end

endmodule : tcf_timer

// [logic/tcf_pkg.sv]
// tcf_pkg: constants and carrier types of the timer capture/compare block.
// assumes byte registers sit one per 32-bit word, byte address = 4 * index.
package tcf_pkg;

   // ---------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------------
   localparam logic [5:0] IDX_CTRL     = 6'h12;
   localparam logic [5:0] IDX_FLAGS    = 6'h13;
   localparam logic [5:0] IDX_CAP1_HI  = 6'h14;
   localparam logic [5:0] IDX_CAP1_LO  = 6'h15;
   localparam logic [5:0] IDX_CMP1_HI  = 6'h16;
   localparam logic [5:0] IDX_CMP1_LO  = 6'h17;
   localparam logic [5:0] IDX_CNT_HI   = 6'h18;
   localparam logic [5:0] IDX_CNT_LO   = 6'h19;
   localparam logic [5:0] IDX_ALT_HI   = 6'h1A;
   localparam logic [5:0] IDX_ALT_LO   = 6'h1B;
   localparam logic [5:0] IDX_CAP2_HI  = 6'h1C;
   localparam logic [5:0] IDX_CAP2_LO  = 6'h1D;
   localparam logic [5:0] IDX_CMP2_HI  = 6'h1E;
   localparam logic [5:0] IDX_CMP2_LO  = 6'h1F;

   // ---------------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------------
   localparam int CTRL_CAP_IE_BIT  = 7;
   localparam int CTRL_CMP_IE_BIT  = 6;
   localparam int CTRL_OVF_IE_BIT  = 5;
   localparam int CTRL_EDGE1_BIT   = 1;
   localparam int CTRL_LEVEL1_BIT  = 0;
   localparam int FLG_CAP1_BIT     = 7;
   localparam int FLG_CMP1_BIT     = 6;
   localparam int FLG_OVF_BIT      = 5;
   localparam int FLG_CAP2_BIT     = 4;
   localparam int FLG_CMP2_BIT     = 3;

   // ---------------------------------------------------------------------
   // reset values and timing
   // ---------------------------------------------------------------------
   localparam logic [15:0] CNT_PRESET   = 16'hFFFC;
   localparam logic [15:0] CNT_TOP      = 16'hFFFF;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam int          PRESC_DIV    = 4;
   localparam logic        LEVEL_RESET  = 1'b0;

   typedef struct packed {
      logic capture_irq_enable;
      logic compare_irq_enable;
      logic overflow_irq_enable;
      logic capture_one_edge_select;
      logic compare_one_level;
   } tcf_ctrl_t;

   typedef struct packed {
      logic capture_one_flag;
      logic compare_one_flag;
      logic overflow_flag;
      logic capture_two_flag;
      logic compare_two_flag;
   } tcf_flags_t;

   function automatic logic [7:0] tcf_addr(input logic [5:0] idx);
      tcf_addr = {idx, 2'b00};
   endfunction : tcf_addr

endpackage : tcf_pkg

// [verification/tcf_timer_sva.sv]
// tcf_timer_sva: port checks of tcf_timer, bound after the module.
// assumes one clock domain, reset RST active high.
`timescale 1ns/10ps
module tcf_timer_sva #(
   parameter int DIV = 4
) (
   input wire logic        CLOCK,
   input wire logic        RST,
   input wire logic        CE,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        CAPTURE_ONE_PIN,
   input wire logic        CAPTURE_TWO_PIN,
   input wire logic        COMPARE_TWO_MATCH,
   input wire logic        COMPARE_ONE_PIN,
   input wire logic        TIMER_IRQ
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);

   logic [7:0] ctrl_q;
   wire logic  setup    = PSEL && !PENABLE && CE;
   wire logic  rd_done  = PSEL && PENABLE && PREADY && !PWRITE;
   wire logic  wr_ctrl  = PSEL && PENABLE && PREADY && PWRITE
                          && PADDR == 8'h48 && CE;
   wire logic  unmapped = PADDR[7:2] < 6'h12 || PADDR[7:2] > 6'h1F;

   // spare bits 4:2 read back as zero
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ctrl_q <= 8'h00;
      end else if (wr_ctrl) begin
         ctrl_q <= PWDATA[7:0] & 8'hE3;
      end
   end

   chk_ready_next: assert property (
      setup && PADDR[1:0] == 2'b00 |=> PREADY && PSLVERR == unmapped)
      else $error("setup not answered in the next cycle");
   chk_ready_single: assert property (
      PREADY && CE |=> !PREADY)
      else $error("ready held longer than one cycle");
   chk_err_ready: assert property (
      PSLVERR |-> PREADY && PSEL && PENABLE)
      else $error("error outside an access cycle");
   chk_byte_wide: assert property (
      rd_done |-> PRDATA[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   chk_flag_spare: assert property (
      rd_done && PADDR == 8'h4C |-> PRDATA[2:0] == 3'h0)
      else $error("spare status bits not zero");
   chk_ctrl_echo: assert property (
      rd_done && PADDR == 8'h48 |-> PRDATA[7:0] == ctrl_q)
      else $error("control readback differs from last write");
   chk_cmp2_zero: assert property (
      rd_done && PADDR[7:3] == 5'h0F |-> PRDATA == 32'h0)
      else $error("compare two bytes not read as zero");
   chk_irq_enable: assert property (
      TIMER_IRQ |-> $past(ctrl_q[7:5]) != 3'b000)
      else $error("interrupt with all enables off");
   chk_irq_drop: assert property (
      wr_ctrl && PWDATA[7:5] == 3'b000 |-> ##[1:2] !TIMER_IRQ)
      else $error("interrupt stays after enables cleared");

   cover property (rd_done && PADDR == 8'h4C && PRDATA[5]);
   cover property (PSLVERR);
   cover property ($rose(TIMER_IRQ));
   cover property ($fell(COMPARE_ONE_PIN));
endmodule : tcf_timer_sva

bind tcf_timer tcf_timer_sva #(.DIV(DIV)) u_chk (
   .CLOCK(CLOCK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .CAPTURE_ONE_PIN(CAPTURE_ONE_PIN),
   .CAPTURE_TWO_PIN(CAPTURE_TWO_PIN), .COMPARE_TWO_MATCH(COMPARE_TWO_MATCH),
   .COMPARE_ONE_PIN(COMPARE_ONE_PIN), .TIMER_IRQ(TIMER_IRQ));

// [verification/tcf_cpu_model.sv]
// tcf_cpu_model: processor side of the register bus, one transfer a call.
// assumes the caller passes an idle gap; at least one idle edge between.
`timescale 1ns/10ps
module tcf_cpu_model (
   input  wire logic        CLOCK,
   input  wire logic [31:0] PRDATA,
   input  wire logic        PREADY,
   output logic             PSEL,
   output logic             PENABLE,
   output logic             PWRITE,
   output logic [7:0]       PADDR,
   output logic [31:0]      PWDATA
);
   initial begin
      PSEL    = 1'b0;
      PENABLE = 1'b0;
      PWRITE  = 1'b0;
      PADDR   = 8'h00;
      PWDATA  = 32'h0;
   end

   task automatic xfer(input logic wr, input logic [5:0] idx,
                       input logic [7:0] d, input int gap,
                       output logic [31:0] r, output logic ok);
      int n = 0;
      repeat (gap + 1) @(posedge CLOCK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= wr;
      PADDR   <= {idx, 2'b00};
      PWDATA  <= {24'h0, d};
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      @(posedge CLOCK);
      // request held until ready is seen at an edge
      while (PREADY !== 1'b1 && n < 50) begin
         @(posedge CLOCK);
         n++;
      end
      r = PRDATA;
      ok = n < 50;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask : xfer
endmodule : tcf_cpu_model

// [verification/timer_capture_compare_flags_tb.sv]
// timer_capture_compare_flags_tb: self-checking bench for tcf_timer.
// assumes tcf_cpu_model as bus master; pins driven here.
`timescale 1ns/10ps
module timer_capture_compare_flags_tb;
   import tcf_pkg::*;

   typedef struct packed {
      logic [31:0] exp;
      logic [31:0] msk;
      logic        err;
   } tcf_note_t;

   logic        CLOCK = 1'b0;
   logic        RST = 1'b1;
   logic        CE = 1'b1;
   logic        CAPTURE_ONE_PIN = 1'b0;
   logic        CAPTURE_TWO_PIN = 1'b0;
   logic        COMPARE_TWO_MATCH = 1'b0;
   logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic        COMPARE_ONE_PIN, TIMER_IRQ;
   logic [7:0]  PADDR, b;
   logic [31:0] PWDATA, PRDATA, q;
   logic [15:0] v;
   tcf_note_t   notes[$];
   tcf_note_t   note;
   int          errors = 0;
   int          n_tests = 0;
   int          seed = 26;

   initial begin
      forever #10 CLOCK = ~CLOCK;
   end

   tcf_timer #(.DIV(PRESC_DIV)) dut (
      .CLOCK(CLOCK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .CAPTURE_ONE_PIN(CAPTURE_ONE_PIN),
      .CAPTURE_TWO_PIN(CAPTURE_TWO_PIN), .TIMER_IRQ(TIMER_IRQ),
      .COMPARE_TWO_MATCH(COMPARE_TWO_MATCH),
      .COMPARE_ONE_PIN(COMPARE_ONE_PIN));

   tcf_cpu_model cpu (
      .CLOCK(CLOCK), .PRDATA(PRDATA), .PREADY(PREADY), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA));

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [5:0] idx,
                      input logic [7:0] d);
      logic ok;
      cpu.xfer(wr, idx, d, {$random(seed)} % 3, q, ok);
      if (!ok) begin
         errors++;
         tally_and_finish();
      end
   endtask : bus

   task automatic rd(input logic [5:0] idx, input logic [31:0] exp,
                     input logic [31:0] msk, input logic err);
      notes.push_back('{exp, msk, err});
      bus(1'b0, idx, 8'h00);
   endtask : rd

   task automatic ticks(input int n);
      repeat (n) @(posedge CLOCK);
   endtask : ticks

   // target twelve counts ahead of a frozen counter read
   task automatic near_count;
      rd(IDX_CNT_HI, 32'h0, 32'h0, 1'b0);
      b = q[7:0];
      rd(IDX_CNT_LO, 32'h0, 32'h0, 1'b0);
      v = {b, q[7:0]} + 16'h000C;
   endtask : near_count

   always @(posedge CLOCK) begin
      if (PSEL && PENABLE && PREADY && !PWRITE && notes.size() > 0) begin
         note = notes.pop_front();
         check("read data", note.exp & note.msk, PRDATA & note.msk);
         check("bus error", {31'h0, note.err}, {31'h0, PSLVERR});
      end
   end

   initial begin
      ticks(10);
      RST <= 1'b0;
      rd(IDX_CTRL, {24'h0, CTRL_RESET}, 32'hFF, 1'b0);
      ticks(24);
      rd(IDX_FLAGS, 32'h20, 32'h20, 1'b0);
      rd(IDX_ALT_LO, 32'h0, 32'h0, 1'b0);
      rd(IDX_FLAGS, 32'h20, 32'h20, 1'b0);
      rd(IDX_CNT_LO, 32'h0, 32'h0, 1'b0);
      rd(IDX_FLAGS, 32'h0, 32'h20, 1'b0);
      rd(6'h11, 32'h0, 32'h0, 1'b1);
      rd(6'h20, 32'h0, 32'h0, 1'b1);
      bus(1'b1, IDX_FLAGS, 8'hFF);
      rd(IDX_FLAGS, 32'h0, 32'hFFFF_FFBF, 1'b0);
      for (int i = 0; i < 4; i++) begin
         q = $random(seed);
         v = q[15:0];
         b = q[23:16];
         bus(1'b1, IDX_CMP1_HI, v[15:8]);
         bus(1'b1, IDX_CMP1_LO, v[7:0]);
         bus(1'b1, IDX_CMP1_HI, b);
         rd(IDX_CMP1_HI, {24'h0, b}, 32'hFF, 1'b0);
         rd(IDX_CMP1_LO, {24'h0, v[7:0]}, 32'hFF, 1'b0);
      end
      bus(1'b1, IDX_CTRL, 8'h41);
      near_count();
      bus(1'b1, IDX_CMP1_HI, v[15:8]);
      rd(IDX_FLAGS, 32'h0, 32'h0, 1'b0);
      bus(1'b1, IDX_CMP1_LO, v[7:0]);
      check("compare pin", 32'h0, {31'h0, COMPARE_ONE_PIN});
      ticks(70);
      check("compare pin", 32'h1, {31'h0, COMPARE_ONE_PIN});
      check("timer irq", 32'h1, {31'h0, TIMER_IRQ});
      rd(IDX_FLAGS, 32'h40, 32'h40, 1'b0);
      bus(1'b1, IDX_CMP1_LO, v[7:0]);
      ticks(2);
      check("timer irq", 32'h0, {31'h0, TIMER_IRQ});
      rd(IDX_FLAGS, 32'h0, 32'h40, 1'b0);
      bus(1'b1, IDX_CTRL, 8'h00);
      near_count();
      bus(1'b1, IDX_CMP1_LO, v[7:0]);
      bus(1'b1, IDX_CMP1_HI, v[15:8]);
      ticks(70);
      check("compare pin", 32'h1, {31'h0, COMPARE_ONE_PIN});
      near_count();
      bus(1'b1, IDX_CMP1_HI, v[15:8]);
      bus(1'b1, IDX_CMP1_LO, v[7:0]);
      ticks(70);
      check("compare pin", 32'h0, {31'h0, COMPARE_ONE_PIN});
      // pin parked at the selected idle level while the old select holds,
      // so each pass sees the unselected edge first
      for (int e = 0; e < 2; e++) begin
         CAPTURE_ONE_PIN <= e[0];
         bus(1'b1, IDX_CTRL, {6'h20, e[0], 1'b0});
         CAPTURE_ONE_PIN <= ~e[0];
         ticks(3);
         rd(IDX_FLAGS, 32'h0, 32'h80, 1'b0);
         CAPTURE_ONE_PIN <= e[0];
         ticks(3);
         check("timer irq", 32'h1, {31'h0, TIMER_IRQ});
         rd(IDX_FLAGS, 32'h80, 32'h80, 1'b0);
         rd(IDX_CAP1_LO, 32'h0, 32'h0, 1'b0);
         rd(IDX_FLAGS, 32'h0, 32'h80, 1'b0);
      end
      rd(IDX_CAP1_HI, 32'h0, 32'h0, 1'b0);
      rd(IDX_CAP1_LO, 32'h0, 32'h0, 1'b0);
      b = q[7:0];
      rd(IDX_CAP1_HI, 32'h0, 32'h0, 1'b0);
      CAPTURE_ONE_PIN <= 1'b0;
      ticks(3);
      CAPTURE_ONE_PIN <= 1'b1;
      ticks(3);
      rd(IDX_CAP1_LO, {24'h0, b}, 32'hFF, 1'b0);
      CAPTURE_TWO_PIN <= 1'b1;
      ticks(3);
      rd(IDX_FLAGS, 32'h0, 32'h10, 1'b0);
      CAPTURE_TWO_PIN <= 1'b0;
      ticks(3);
      rd(IDX_FLAGS, 32'h10, 32'h10, 1'b0);
      rd(IDX_CAP2_LO, 32'h0, 32'h0, 1'b0);
      rd(IDX_FLAGS, 32'h0, 32'h10, 1'b0);
      // clock enable low: a match pulse in that time must not be seen
      CE <= 1'b0;
      COMPARE_TWO_MATCH <= 1'b1;
      ticks(2);
      COMPARE_TWO_MATCH <= 1'b0;
      ticks(1);
      CE <= 1'b1;
      rd(IDX_FLAGS, 32'h0, 32'h8, 1'b0);
      COMPARE_TWO_MATCH <= 1'b1;
      ticks(1);
      COMPARE_TWO_MATCH <= 1'b0;
      ticks(2);
      rd(IDX_FLAGS, 32'h8, 32'h8, 1'b0);
      bus(1'b1, IDX_CMP2_LO, 8'h00);
      rd(IDX_FLAGS, 32'h0, 32'h8, 1'b0);
      ticks(4);
      tally_and_finish();
   end
endmodule : timer_capture_compare_flags_tb
